// *** rtl/level_dac_ctrl.sv ***
// Purpose: control logic of a five-bit ratiometric level converter
// Assumes: plain strobe register port, 125 MHz clock, no sleep clock gate
// Notes: the ladder and pads are analog; this drives their static controls
// Functional notes
// - converter runs only while enable bit 7 is one
// - five-bit level code picks one of 32 levels
// - level is low source plus span times code over 32
// - bits 5 and 4 route level to pin one and pin two
// - routed pin loses driver, input detector and weak pull-up
// - digital read of a routed pin always returns zero
// - bits 3-2 pick supply, reference pin or fixed reference
// - bit 0 picks low reference pin when one, ground when zero
// - keeps running in sleep; wake leaves control register intact
// - reset disables, unroutes pins and clears level code
// - unimplemented bits ignore writes and read as zero
`timescale 1ns/10ps
module level_dac_ctrl (
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // synchronous reset
    input wire logic [level_dac_pkg::ADDR_W-1:0] addr_i, // register index
    input wire logic [level_dac_pkg::DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [level_dac_pkg::DATA_W-1:0] rdata_o, // read data
    input wire logic pin_one_i, // raw pad level, pin one
    input wire logic pin_two_i, // raw pad level, pin two
    output level_dac_pkg::analog_ctrl_s analog_o, // ladder controls
    output level_dac_pkg::pos_sel_s pos_sel_o, // top source one-hot
    output logic neg_ref_pin_o, // bottom end on reference pin
    output logic [31:0] tap_sel_o, // one-hot ladder tap
    output level_dac_pkg::pad_ctrl_s pad_one_o, // pin one overrides
    output level_dac_pkg::pad_ctrl_s pad_two_o, // pin two overrides
    output logic pin_one_read_o, // digital read, pin one
    output logic pin_two_read_o // digital read, pin two
);
    import level_dac_pkg::*;

    bus_req_s req;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] lvl_q;
    logic we_ctrl;
    logic we_lvl;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    analog_ctrl_s ana_r;
    analog_ctrl_s ana_nxt;
    pos_sel_s pos_r;
    pos_sel_s pos_nxt;
    logic neg_r;
    logic neg_nxt;
    logic [31:0] tap_r;
    logic [31:0] tap_nxt;
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;

    assign req.wr = wr_i;
    assign req.rd = rd_i;
    assign req.addr = addr_i;
    assign req.wdata = wdata_i;

    // write decode; sleep has no path here so contents stay put
    always_comb begin
        we_ctrl = 1'b0;
        we_lvl = 1'b0;
        if (req.wr && req.addr == OFS_CONTROL_MAIN) begin
            we_ctrl = 1'b1;
        end else if (req.wr && req.addr == OFS_LEVEL_SELECT) begin
            we_lvl = 1'b1;
        end
    end

    // control register, reserved bits 6 and 1 masked off
    level_dac_regs #(
        .MASK(MASK_CONTROL_MAIN),
        .RST(RST_CONTROL_MAIN)
    ) u_ctrl_main (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(we_ctrl),
        .wdata_i(req.wdata),
        .q_o(ctrl_q)
    );

    // level register, bits 7-5 masked off
    level_dac_regs #(
        .MASK(MASK_LEVEL_SELECT),
        .RST(RST_LEVEL_SELECT)
    ) u_level_select (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(we_lvl),
        .wdata_i(req.wdata),
        .q_o(lvl_q)
    );

    // read mux; status echoes what the macro is actually given
    always_comb begin
        rdata_nxt = '0;
        if (req.rd && req.addr == OFS_CONTROL_MAIN) begin
            rdata_nxt = ctrl_q;
        end else if (req.rd && req.addr == OFS_LEVEL_SELECT) begin
            rdata_nxt = lvl_q;
        end else if (req.rd && req.addr == OFS_STATUS) begin
            rdata_nxt = {ana_r.converter_enable, 2'h0, tap_r[0],
                         pin_one_read_o, pin_two_read_o,
                         ana_r.level_pin_one_enable,
                         ana_r.level_pin_two_enable};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // macro controls follow the stored fields, one edge after a write
    always_comb begin
        ana_nxt.converter_enable = ctrl_q[BIT_ENABLE];
        ana_nxt.level_pin_one_enable = ctrl_q[BIT_ENABLE]
            & ctrl_q[BIT_PIN_ONE];
        ana_nxt.level_pin_two_enable = ctrl_q[BIT_ENABLE]
            & ctrl_q[BIT_PIN_TWO];
        ana_nxt.positive_source_select = ctrl_q[BIT_PSS_HI:BIT_PSS_LO];
        ana_nxt.negative_source_select = ctrl_q[BIT_NSS];
        ana_nxt.level_code = lvl_q[LEVEL_W-1:0];
    end

    // source selection; reserved code selects nothing, a safe open top
    always_comb begin
        pos_nxt = '0;
        case (ctrl_q[BIT_PSS_HI:BIT_PSS_LO])
            PSS_SUPPLY: pos_nxt.supply = ctrl_q[BIT_ENABLE];
            PSS_REF_PIN: pos_nxt.ref_pin = ctrl_q[BIT_ENABLE];
            PSS_FIXED_REF: begin
                pos_nxt.fixed_voltage_reference = ctrl_q[BIT_ENABLE];
            end
            default: pos_nxt = '0;
        endcase
        neg_nxt = ctrl_q[BIT_ENABLE] & ctrl_q[BIT_NSS];
    end

    // tap k of 32 gives low + span*k/32; off leaves every tap open
    always_comb begin
        tap_nxt = '0;
        if (ctrl_q[BIT_ENABLE]) begin
            tap_nxt[lvl_q[LEVEL_W-1:0]] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ana_r <= '0;
            pos_r <= '0;
            neg_r <= 1'b0;
            tap_r <= '0;
        end else begin
            ana_r <= ana_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
            tap_r <= tap_nxt;
        end
    end

    assign analog_o = ana_r;
    assign pos_sel_o = pos_r;
    assign neg_ref_pin_o = neg_r;
    assign tap_sel_o = tap_r;

    // two-flop synchronisers for the asynchronous pad levels
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {pin_two_i, pin_one_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    // pad overrides per pin
    level_pad_ctrl u_pad_one (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .route_i(ana_nxt.level_pin_one_enable),
        .pin_sync_i(pin_s2_r[0]),
        .pad_o(pad_one_o),
        .pin_read_o(pin_one_read_o)
    );

    level_pad_ctrl u_pad_two (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .route_i(ana_nxt.level_pin_two_enable),
        .pin_sync_i(pin_s2_r[1]),
        .pad_o(pad_two_o),
        .pin_read_o(pin_two_read_o)
    );
endmodule : level_dac_ctrl

// *** rtl/level_dac_pkg.sv ***
// Purpose: shared constants and carriers for the five-bit level converter
// Assumes: 8-bit registers on a plain strobe port, one clock
// Notes: offsets are register indices on the plain port
package level_dac_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int LEVEL_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_MAIN = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_SELECT = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PIN_ONE = 5;
    localparam int BIT_PIN_TWO = 4;
    localparam int BIT_PSS_HI = 3;
    localparam int BIT_PSS_LO = 2;
    localparam int BIT_NSS = 0;
    localparam logic [DATA_W-1:0] MASK_CONTROL_MAIN = 8'hbd;
    localparam logic [DATA_W-1:0] MASK_LEVEL_SELECT = 8'h1f;
    localparam logic [DATA_W-1:0] RST_CONTROL_MAIN = 8'h00;
    localparam logic [DATA_W-1:0] RST_LEVEL_SELECT = 8'h00;
    localparam logic [1:0] PSS_SUPPLY = 2'h0;
    localparam logic [1:0] PSS_REF_PIN = 2'h1;
    localparam logic [1:0] PSS_FIXED_REF = 2'h2;
    localparam logic [1:0] PSS_RESERVED = 2'h3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic converter_enable;
        logic level_pin_one_enable;
        logic level_pin_two_enable;
        logic [1:0] positive_source_select;
        logic negative_source_select;
        logic [LEVEL_W-1:0] level_code;
    } analog_ctrl_s;

    // one-hot selection into the ladder top end
    typedef struct packed {
        logic fixed_voltage_reference;
        logic ref_pin;
        logic supply;
    } pos_sel_s;

    typedef struct packed {
        logic pad_analog;
        logic out_drv_off;
        logic in_det_off;
        logic pullup_off;
    } pad_ctrl_s;
endpackage : level_dac_pkg

// *** rtl/level_dac_regs.sv ***
// Purpose: masked 8-bit control register with write-only-implemented bits
// Assumes: synchronous active-high reset
// Notes: unimplemented bits never store and read as zero
`timescale 1ns/10ps
module level_dac_regs #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RST = 8'h00
) (
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // synchronous reset
    input wire logic we_i, // write this register
    input wire logic [7:0] wdata_i, // write data
    output logic [7:0] q_o // stored value, masked
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // masked update keeps reserved bits at zero
    always_comb begin
        q_nxt = q_r;
        if (we_i) begin
            q_nxt = wdata_i & MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : level_dac_regs

// *** rtl/level_pad_ctrl.sv ***
// Purpose: pad override for one converter level output pin
// Assumes: pin digital input already synchronised by the caller
// Notes: digital read forced low while the pad carries the level
`timescale 1ns/10ps
module level_pad_ctrl (
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // synchronous reset
    input wire logic route_i, // level routed to this pin
    input wire logic pin_sync_i, // synchronised pin level
    output level_dac_pkg::pad_ctrl_s pad_o, // pad override controls
    output logic pin_read_o // digital read value
);
    import level_dac_pkg::*;
    pad_ctrl_s pad_r;
    pad_ctrl_s pad_nxt;
    logic read_r;
    logic read_nxt;

    // route overrides driver, detector and pull-up together
    always_comb begin
        pad_nxt.pad_analog = route_i;
        pad_nxt.out_drv_off = route_i;
        pad_nxt.in_det_off = route_i;
        pad_nxt.pullup_off = route_i;
        read_nxt = route_i ? 1'b0 : pin_sync_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pad_r <= '0;
            read_r <= 1'b0;
        end else begin
            pad_r <= pad_nxt;
            read_r <= read_nxt;
        end
    end

    assign pad_o = pad_r;
    assign pin_read_o = read_r;
endmodule : level_pad_ctrl

// *** testbench/level_dac_ctrl_checker.sv ***
// Purpose: port assertions for the level converter control
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the control top; sees its ports only
`timescale 1ns/10ps
module level_dac_ctrl_checker
    import level_dac_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic sys_rst_i, // reset
    input wire logic [ADDR_W-1:0] addr_i, // index
    input wire logic [DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [DATA_W-1:0] rdata_o, // read data
    input wire analog_ctrl_s analog_o, // ladder controls
    input wire pos_sel_s pos_sel_o, // top source
    input wire logic neg_ref_pin_o, // bottom source
    input wire logic [31:0] tap_sel_o, // tap
    input wire pad_ctrl_s pad_one_o, // pin one pad
    input wire logic pin_one_read_o // pin one read
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a write reaches the macro two edges after its strobe
    sequence s_wr_main;
        wr_i && addr_i == OFS_CONTROL_MAIN;
    endsequence
    sequence s_wr_level;
        wr_i && addr_i == OFS_LEVEL_SELECT;
    endsequence
    property p_main;
        s_wr_main |-> ##2 (analog_o.converter_enable == $past(wdata_i[7], 2)
            && analog_o.level_pin_one_enable
            == $past(wdata_i[7] & wdata_i[5], 2));
    endproperty
    a_main: assert property (p_main) else $error("main write lost");
    property p_level;
        s_wr_level |-> ##2 analog_o.level_code == $past(wdata_i[4:0], 2);
    endproperty
    a_level: assert property (p_level) else $error("code lost");
    property p_tap;
        tap_sel_o == (analog_o.converter_enable ?
            32'h1 << analog_o.level_code : 32'h0);
    endproperty
    a_tap: assert property (p_tap) else $error("tap wrong");
    property p_pos;
        pos_sel_o == ((analog_o.converter_enable &&
            analog_o.positive_source_select != PSS_RESERVED) ?
            3'(3'h1 << analog_o.positive_source_select) : 3'h0);
    endproperty
    a_pos: assert property (p_pos) else $error("top source wrong");
    property p_neg;
        neg_ref_pin_o == (analog_o.converter_enable &&
            analog_o.negative_source_select);
    endproperty
    a_neg: assert property (p_neg) else $error("bottom wrong");
    property p_pad;
        pad_one_o == {4{analog_o.level_pin_one_enable}};
    endproperty
    a_pad: assert property (p_pad) else $error("pad wrong");
    property p_read;
        analog_o.level_pin_one_enable |-> !pin_one_read_o;
    endproperty
    a_read: assert property (p_read) else $error("routed read");
    property p_unimpl;
        rd_i && addr_i == OFS_LEVEL_SELECT |=> rdata_o[7:5] == 3'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("upper bits");
    property p_hold;
        !$past(wr_i) && !$past(wr_i, 2) && !$past(sys_rst_i)
            |-> $stable(analog_o);
    endproperty
    a_hold: assert property (p_hold) else $error("control moved");
endmodule : level_dac_ctrl_checker

bind level_dac_ctrl level_dac_ctrl_checker u_level_dac_ctrl_checker (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .analog_o(analog_o), .pos_sel_o(pos_sel_o),
    .neg_ref_pin_o(neg_ref_pin_o), .tap_sel_o(tap_sel_o),
    .pad_one_o(pad_one_o), .pin_one_read_o(pin_one_read_o));

// *** testbench/level_dac_ctrl_tb.sv ***
// Purpose: register and pin level checks of the level converter control
// Assumes: strobe port, 125 MHz clock
// Notes: source values live in the ladder model defaults
`timescale 1ns/10ps
module level_dac_ctrl_tb;
    import level_dac_pkg::*;
    logic clk_i, sys_rst_i, wr_i, rd_i, pin_one, pin_two, ext_one, ext_two;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o;
    analog_ctrl_s analog_o;
    pos_sel_s pos_sel_o;
    logic neg_ref_pin_o, rd_one, rd_two;
    logic [31:0] tap_sel_o;
    pad_ctrl_s pad_one_o, pad_two_o;
    int level_mv, mismatches, samples_checked, cycles, code, exp_mv;
    int top_mv[3] = '{3300, 2048, 1024};
    level_dac_ctrl u_level_dac_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_one_i(pin_one), .pin_two_i(pin_two),
        .analog_o(analog_o), .pos_sel_o(pos_sel_o),
        .neg_ref_pin_o(neg_ref_pin_o), .tap_sel_o(tap_sel_o),
        .pad_one_o(pad_one_o), .pad_two_o(pad_two_o),
        .pin_one_read_o(rd_one), .pin_two_read_o(rd_two));
    level_ladder_model u_level_ladder_model (.pos_sel_i(pos_sel_o),
        .neg_ref_pin_i(neg_ref_pin_o), .tap_sel_i(tap_sel_o),
        .pad_one_i(pad_one_o), .pad_two_i(pad_two_o), .ext_one_i(ext_one),
        .ext_two_i(ext_two), .level_mv_o(level_mv), .pin_one_o(pin_one),
        .pin_two_o(pin_two));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic report_and_stop;
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // hang guard: the whole sequence needs far fewer cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk({24'h0, rdata_o}, {24'h0, e});
    endtask : rd
    // pin reads pass two sync flops and a register
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle
    initial begin
        {wr_i, rd_i, addr_i, wdata_i} = '0;
        sys_rst_i = 1'b1;
        {ext_one, ext_two} = 2'b11;
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(OFS_CONTROL_MAIN, RST_CONTROL_MAIN);
        rd(OFS_LEVEL_SELECT, RST_LEVEL_SELECT);
        wr(OFS_CONTROL_MAIN, 8'hf3);
        wr(OFS_LEVEL_SELECT, 8'hff);
        wr(4'hf, 8'hff);
        rd(OFS_CONTROL_MAIN, 8'hb1);
        rd(OFS_LEVEL_SELECT, 8'h1f);
        rd(4'hf, 8'h00);
        settle();
        chk({24'h0, pad_one_o, pad_two_o}, 32'hff);
        chk({30'h0, rd_one, rd_two}, 32'h0);
        // every legal top source against both bottoms; p stops short of 3
        for (int p = 0; p < 3; p++) for (int n = 0; n < 2; n++) begin
            code = (p * 11 + n * 31) % 32;
            exp_mv = n * 500 + (top_mv[p] - n * 500) * code / 32;
            wr(OFS_CONTROL_MAIN, {4'h8, 2'(p), 1'b0, 1'(n)});
            wr(OFS_LEVEL_SELECT, 8'(code));
            settle();
            chk({29'h0, pos_sel_o}, 32'h1 << p);
            chk({31'h0, neg_ref_pin_o}, n);
            chk(level_mv, exp_mv);
        end
        wr(OFS_CONTROL_MAIN, 8'h31);
        ext_two <= 1'b0;
        settle();
        chk(tap_sel_o, 32'h0);
        chk({24'h0, pad_one_o, pad_two_o}, 32'h0);
        chk({30'h0, rd_one, rd_two}, 32'h2);
        wr(OFS_CONTROL_MAIN, 8'ha0);
        settle();
        chk({24'h0, pad_one_o, pad_two_o}, 32'hf0);
        wr(OFS_CONTROL_MAIN, 8'h90);
        settle();
        chk({24'h0, pad_one_o, pad_two_o}, 32'h0f);
        // idle cycles leave the control word as written
        rd(OFS_CONTROL_MAIN, 8'h90);
        // status: enable, pin one reads high, pin two routed
        rd(OFS_STATUS, 8'h89);
        @(posedge clk_i) sys_rst_i <= 1'b1;
        @(posedge clk_i) sys_rst_i <= 1'b0;
        #1 chk({21'h0, analog_o}, 32'h0);
        rd(OFS_CONTROL_MAIN, 8'h00);
        rd(OFS_LEVEL_SELECT, 8'h00);
        report_and_stop();
    end
endmodule : level_dac_ctrl_tb

// *** testbench/level_ladder_model.sv ***
// Purpose: behavioural ladder and pad pair behind the control
// Assumes: sources in millivolts, a fixed digital threshold
// Notes: a routed pad shows the ladder level, not the external drive
`timescale 1ns/10ps
module level_ladder_model
    import level_dac_pkg::*;
#(
    parameter int SUP_MV = 3300,
    parameter int REFP_MV = 2048,
    parameter int FIX_MV = 1024,
    parameter int NEG_MV = 500,
    parameter int THR_MV = 1650
) (
    input wire pos_sel_s pos_sel_i, // top source
    input wire logic neg_ref_pin_i, // bottom source
    input wire logic [31:0] tap_sel_i, // tap
    input wire pad_ctrl_s pad_one_i, // pin one pad
    input wire pad_ctrl_s pad_two_i, // pin two pad
    input wire logic ext_one_i, // external drive one
    input wire logic ext_two_i, // external drive two
    output int level_mv_o, // ladder level
    output logic pin_one_o, // pin one level
    output logic pin_two_o // pin two level
);
    int top;
    int bot;
    // ratiometric: no tap selected means the ladder is dark
    always_comb begin
        top = pos_sel_i.supply ? SUP_MV : pos_sel_i.ref_pin ? REFP_MV :
            pos_sel_i.fixed_voltage_reference ? FIX_MV : 0;
        bot = neg_ref_pin_i ? NEG_MV : 0;
        level_mv_o = (tap_sel_i == 32'h0) ? 0 :
            bot + (top - bot) * $clog2(tap_sel_i) / 32;
    end
    // routed pad is driven by the level, so a high level reads as one
    assign pin_one_o = pad_one_i.pad_analog ? level_mv_o > THR_MV
        : ext_one_i;
    assign pin_two_o = pad_two_i.pad_analog ? level_mv_o > THR_MV
        : ext_two_i;
endmodule : level_ladder_model
